// ---- efb_pkg.sv ----
// Package for the external flash bus host controller.
`default_nettype none
package efb_pkg;
   // ==========================================
   // Bus widths.
   localparam int ADDR_W = 21;
   localparam int DATA_W = 16;
   // ==========================================
   // Timing in clock cycles at 10 MHz (100 ns period).
   localparam int CLK_PERIOD_NS   = 100;
   localparam int SETUP_NS        = 100;
   localparam int STROBE_NS       = 200;
   localparam int HOLD_NS         = 100;
   localparam int SETUP_CYC       = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_CYC      = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC        = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] CNT_RST = 4'h0;
   // ==========================================
   // Host request carrier.
   typedef struct packed {
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } efb_req_t;
   // ==========================================
   // Transfer states, Gray coded from ST_IDLE to ST_OFF; the return to ST_IDLE flips two bits.
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_SETUP  = 3'b001,
      ST_STROBE = 3'b011,
      ST_HOLD   = 3'b010,
      ST_OFF    = 3'b110
   } efb_state_t;
endpackage
`default_nettype wire

// ---- efb_host.sv ----
// Host controller that drives the external flash bus pins.
`default_nettype none
module efb_host
   import efb_pkg::*;
(
   // Clock and reset.
   input  wire logic              mclk_i,
   input  wire logic              rstn_i,
   // User side.
   input  wire logic              req_valid_i,
   input  wire efb_req_t          req_i,
   input  wire logic              bus_grant_i,
   input  wire logic              flash_reset_req_i,
   output logic                   req_ready_o,
   output logic                   rd_valid_o,
   output logic [DATA_W-1:0]      rd_data_o,
   // Flash pins; output enables are active low.
   output logic [ADDR_W-1:0]      addr_o,
   output logic                   addr_oen_o,
   input  wire logic [DATA_W-1:0] dq_i,
   output logic [DATA_W-1:0]      dq_o,
   output logic                   dq_oen_o,
   output logic                   ce_n_o,
   output logic                   ctl_oen_o,
   output logic                   oe_n_o,
   output logic                   we_n_o,
   output logic                   flash_reset_n_o,
   output logic                   flash_reset_oen_o
);
   // ==========================================
   // Pin synchronisers.
   logic [DATA_W-1:0] dq_s1_q, dq_s2_q;
   logic              gnt_s1_q, gnt_s2_q;

   // Two flip-flops for every input from outside the clock domain.
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         dq_s1_q  <= '0;
         dq_s2_q  <= '0;
         gnt_s1_q <= 1'b0;
         gnt_s2_q <= 1'b0;
      end else begin
         dq_s1_q  <= dq_i;
         dq_s2_q  <= dq_s1_q;
         gnt_s1_q <= bus_grant_i;
         gnt_s2_q <= gnt_s1_q;
      end
   end

   // ==========================================
   // Transfer sequencer.
   efb_state_t        st_q, st_d;
   logic [3:0]        cnt_q, cnt_d;
   efb_req_t          cur_q, cur_d;
   logic              ready_q, ready_d;
   logic              rdv_q, rdv_d;
   logic [DATA_W-1:0] rdd_q, rdd_d;
   logic              own_q, own_d;
   logic              ce_q, ce_d;
   logic              oe_q, oe_d;
   logic              we_q, we_d;
   logic              dqen_q, dqen_d;
   logic              rst_q, rst_d;

   // Next-state logic for the bus cycle.
   always_comb begin
      st_d    = st_q;
      cnt_d   = cnt_q;
      cur_d   = cur_q;
      rdv_d   = 1'b0;
      rdd_d   = rdd_q;
      own_d   = own_q;
      ce_d    = ce_q;
      oe_d    = oe_q;
      we_d    = we_q;
      dqen_d  = dqen_q;
      rst_d   = rst_q;
      ready_d = 1'b0;
      case (st_q)
         ST_IDLE: begin
            own_d   = gnt_s2_q;
            rst_d   = flash_reset_req_i;
            ce_d    = 1'b0;
            oe_d    = 1'b0;
            we_d    = 1'b0;
            dqen_d  = 1'b0;
            // Ready pulses for one cycle whether or not a request already waits.
            ready_d = gnt_s2_q && own_q && !ready_q;
            if (gnt_s2_q && own_q && req_valid_i && ready_q) begin
               cur_d  = req_i;
               ce_d   = 1'b1;
               dqen_d = req_i.write;
               cnt_d  = 4'(SETUP_CYC);
               st_d   = ST_SETUP;
            end
         end
         ST_SETUP: begin
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
               oe_d  = !cur_q.write;
               we_d  = cur_q.write && !rst_q;
               cnt_d = 4'(STROBE_CYC);
               st_d  = ST_STROBE;
            end
         end
         ST_STROBE: begin
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
               oe_d  = 1'b0;
               we_d  = 1'b0;
               cnt_d = 4'(HOLD_CYC);
               st_d  = ST_HOLD;
            end
         end
         ST_HOLD: begin
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
               // The synchroniser lags two cycles, so the word taken here shows the strobe.
               if (!cur_q.write) begin
                  rdd_d = dq_s2_q;
                  rdv_d = 1'b1;
               end
               dqen_d = 1'b0;
               ce_d   = 1'b0;
               st_d   = ST_OFF;
            end
         end
         ST_OFF: begin
            st_d = ST_IDLE;
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   // Sequencer registers.
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_q    <= ST_IDLE;
         cnt_q   <= CNT_RST;
         cur_q   <= '0;
         ready_q <= 1'b0;
         rdv_q   <= 1'b0;
         rdd_q   <= '0;
         own_q   <= 1'b0;
         ce_q    <= 1'b0;
         oe_q    <= 1'b0;
         we_q    <= 1'b0;
         dqen_q  <= 1'b0;
         rst_q   <= 1'b0;
      end else begin
         st_q    <= st_d;
         cnt_q   <= cnt_d;
         cur_q   <= cur_d;
         ready_q <= ready_d;
         rdv_q   <= rdv_d;
         rdd_q   <= rdd_d;
         own_q   <= own_d;
         ce_q    <= ce_d;
         oe_q    <= oe_d;
         we_q    <= we_d;
         dqen_q  <= dqen_d;
         rst_q   <= rst_d;
      end
   end

   // ==========================================
   // Pin drive, every output straight from a flip-flop.
   assign req_ready_o       = ready_q;
   assign rd_valid_o        = rdv_q;
   assign rd_data_o         = rdd_q;
   assign addr_o            = cur_q.addr;
   assign addr_oen_o        = !own_q;
   assign dq_o              = cur_q.data;
   assign dq_oen_o          = !dqen_q;
   assign ce_n_o            = !ce_q;
   assign ctl_oen_o         = !own_q;
   assign oe_n_o            = !oe_q;
   assign we_n_o            = !we_q;
   assign flash_reset_n_o   = !rst_q;
   assign flash_reset_oen_o = !own_q;

   // ==========================================
   // Assertions.
   property p_no_overlap;
      @(posedge mclk_i) disable iff (!rstn_i) !(oe_q && we_q);
   endproperty
   a_no_overlap: assert property (p_no_overlap)
      else $error("oe and we both asserted");

   property p_read_release;
      @(posedge mclk_i) disable iff (!rstn_i) oe_q |-> !dqen_q;
   endproperty
   a_read_release: assert property (p_read_release)
      else $error("host drives dq on read");

   property p_write_drive;
      @(posedge mclk_i) disable iff (!rstn_i) we_q |-> dqen_q && ce_q;
   endproperty
   a_write_drive: assert property (p_write_drive)
      else $error("write without data drive");

   property p_hold_after_we;
      @(posedge mclk_i) disable iff (!rstn_i)
         $fell(we_q) |-> dqen_q && $stable(cur_q.addr) && $stable(cur_q.data);
   endproperty
   a_hold_after_we: assert property (p_hold_after_we)
      else $error("data not held at we rise");

   property p_no_we_in_reset;
      @(posedge mclk_i) disable iff (!rstn_i) rst_q |-> !we_q;
   endproperty
   a_no_we_in_reset: assert property (p_no_we_in_reset)
      else $error("write during reset");

   property p_release_idle;
      @(posedge mclk_i) disable iff (!rstn_i) !own_q |-> !ce_q && !dqen_q;
   endproperty
   a_release_idle: assert property (p_release_idle)
      else $error("bus driven without grant");

   property p_strobe_len;
      @(posedge mclk_i) disable iff (!rstn_i) $rose(we_q) |-> we_q [*2] ##1 !we_q;
   endproperty
   a_strobe_len: assert property (p_strobe_len)
      else $error("write strobe width wrong");

   property p_oe_len;
      @(posedge mclk_i) disable iff (!rstn_i) $rose(oe_q) |-> oe_q [*2] ##1 !oe_q ##1 rdv_q;
   endproperty
   a_oe_len: assert property (p_oe_len)
      else $error("read strobe or result wrong");
endmodule
`default_nettype wire

// ---- efb_flash_model.sv ----
// Behavioural model of the flash memory on the external bus.
`default_nettype none
module efb_flash_model
   import efb_pkg::*;
(
   // Bus pins as seen at the flash.
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] dq_i,
   input  wire logic              ce_n_i,
   input  wire logic              oe_n_i,
   input  wire logic              we_n_i,
   input  wire logic              rst_n_i,
   // Read data and its drive flag.
   output logic [DATA_W-1:0]      dq_o,
   output logic                   dq_drv_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
   // Address and data are latched at the strobe rise, only when selected and out of reset.
   always @(posedge we_n_i) begin
      if (!ce_n_i && rst_n_i) mem[addr_i] = dq_i;
   end
   // Drivers are on only while selected with output enable low.
   assign dq_drv_o = !ce_n_i && !oe_n_i && rst_n_i;
   // Released lines show the inverse of the host value, never a stale copy.
   always_comb begin
      if (!dq_drv_o) dq_o = ~dq_i;
      else if (mem.exists(addr_i)) dq_o = mem[addr_i];
      else dq_o = 16'hffff;
   end
endmodule
`default_nettype wire

// ---- tb_external_flash_bus_interface.sv ----
// Self-checking testbench for the external flash bus host.
`default_nettype none
module tb_external_flash_bus_interface;
   import efb_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk_i = 0, rstn_i = 0, req_valid_i = 0, bus_grant_i = 0, frq = 0;
   efb_req_t req_i = '0;
   logic req_ready_o, rd_valid_o, addr_oen_o, dq_oen_o, ce_n_o, ctl_oen_o, oe_n_o, we_n_o;
   logic flash_reset_n_o, flash_reset_oen_o, fl_drv, rdy_seen = 0, we_seen = 0;
   logic [DATA_W-1:0] rd_data_o, dq_o, dq_i, fl_dq, got;
   logic [ADDR_W-1:0] addr_o, ad [8];
   logic [DATA_W-1:0] dt [8];
   logic [31:0] rnd = 32'h6cc2_055a;
   int n_fail = 0, compares = 0;
   // Host drives dq while its enable is low, the flash otherwise.
   assign dq_i = dq_oen_o ? fl_dq : dq_o;
   always #50 mclk_i = ~mclk_i;
   efb_host dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .req_valid_i(req_valid_i), .req_i(req_i),
      .bus_grant_i(bus_grant_i), .flash_reset_req_i(frq), .req_ready_o(req_ready_o),
      .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .addr_o(addr_o), .addr_oen_o(addr_oen_o),
      .dq_i(dq_i), .dq_o(dq_o), .dq_oen_o(dq_oen_o), .ce_n_o(ce_n_o), .ctl_oen_o(ctl_oen_o),
      .oe_n_o(oe_n_o), .we_n_o(we_n_o), .flash_reset_n_o(flash_reset_n_o),
      .flash_reset_oen_o(flash_reset_oen_o));
   efb_flash_model fl (.addr_i(addr_oen_o ? ~addr_o : addr_o), .dq_i(dq_o),
      .ce_n_i(ctl_oen_o | ce_n_o), .oe_n_i(ctl_oen_o | oe_n_o), .we_n_i(ctl_oen_o | we_n_o),
      .rst_n_i(flash_reset_oen_o | flash_reset_n_o), .dq_o(fl_dq), .dq_drv_o(fl_drv));
   // Next value of the stimulus shift register.
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // One bus request; read data lands in got.
   task automatic op(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      got = 'x;
      @(negedge mclk_i);
      req_i = {w, a, d};
      req_valid_i = 1'b1;
      do begin
         @(posedge mclk_i);
         n++;
      end while (req_ready_o !== 1'b1 && n < 60);
      check(n < 60, 1, "ready");
      @(negedge mclk_i);
      req_valid_i = 1'b0;
      for (n = 0; n < 12; n++) begin
         if (rd_valid_o === 1'b1) got = rd_data_o;
         @(negedge mclk_i);
      end
   endtask
   // Pin monitors sampled at the falling edge, where the outputs have settled.
   always @(negedge mclk_i) begin
      if (req_ready_o === 1'b1) rdy_seen <= 1;
      if (we_n_o === 1'b0) we_seen <= 1;
      if (rstn_i) check(oe_n_o | we_n_o, 1, "oe_we_overlap");
      if (we_n_o === 1'b0) check(dq_oen_o, 0, "dq_drive_write");
      if (fl_drv) check(dq_oen_o, 1, "dq_release_read");
   end
   initial begin
      #2_000_000;
      check(0, 1, "watchdog");
      stop_test();
   end
   initial begin
      repeat (10) @(negedge mclk_i);
      rstn_i = 1;
      repeat (30) @(negedge mclk_i);
      check({rdy_seen, ctl_oen_o, flash_reset_oen_o, dq_oen_o, addr_oen_o}, 5'h0f,
            "no_grant");
      bus_grant_i = 1;
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         // Random addresses differ from each other and from the corner addresses.
         ad[i] = (i == 0) ? 21'h00_0000 : (i == 1) ? 21'h1f_ffff : {1'b0, rnd[19:3], 3'(i)};
         dt[i] = rnd[31:16] ^ rnd[15:0];
         op(1, ad[i], dt[i]);
      end
      for (int i = 0; i < 8; i++) begin
         op(0, ad[i], 16'h0000);
         check(got, dt[i], "read_back");
      end
      frq = 1;
      repeat (3) @(negedge mclk_i);
      we_seen = 0;
      op(1, ad[0], ~dt[0]);
      check({we_seen, flash_reset_n_o}, 0, "write_in_reset");
      frq = 0;
      op(0, ad[0], 16'h0000);
      check(got, dt[0], "kept_in_reset");
      op(0, ad[1] ^ 21'h00_0001, 16'h0000);
      check(got, 16'hffff, "unwritten");
      stop_test();
   end
endmodule
`default_nettype wire
